// ### core/tcr_pkg.sv
package tcr_pkg;

  // Register file geometry
  localparam int NUM_REGS = 7;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 7;

  // Register offsets
  localparam logic [6:0] ADDR_DIRECTION_CHANNEL = 7'h00;
  localparam logic [6:0] ADDR_TX_POWER_CRYSTAL = 7'h01;
  localparam logic [6:0] ADDR_DATA_FUNCTION_CTRL = 7'h02;
  localparam logic [6:0] ADDR_SIGNAL_LEVEL_CTRL = 7'h03;
  localparam logic [6:0] ADDR_SIGNAL_LEVEL_VALUE_GAIN = 7'h04;
  localparam logic [6:0] ADDR_PACKET_FORMAT_CTRL = 7'h05;
  localparam logic [6:0] ADDR_PREAMBLE_CTRL = 7'h06;
  localparam logic [6:0] ADDR_MAP_LAST = 7'h18;

  // Reset values
  localparam logic [7:0] RST_DIRECTION_CHANNEL = 8'h28;
  localparam logic [7:0] RST_TX_POWER_CRYSTAL = 8'h03;
  localparam logic [7:0] RST_DATA_FUNCTION_CTRL = 8'h78;
  localparam logic [7:0] RST_SIGNAL_LEVEL_CTRL = 8'h87;
  localparam logic [7:0] RST_SIGNAL_LEVEL_VALUE_GAIN = 8'h20;
  localparam logic [7:0] RST_PACKET_FORMAT_CTRL = 8'h0f;
  localparam logic [7:0] RST_PREAMBLE_CTRL = 8'h30;

  // Single-bit field positions
  localparam int POS_TX_MODE = 7;
  localparam int POS_BURST_MODE = 6;
  localparam int POS_BIT_RATE = 5;
  localparam int POS_SCRAMBLE_EN = 4;
  localparam int POS_CRC_EN = 3;
  localparam int POS_CRC_FAIL_KEEP = 0;
  localparam int POS_LEVEL_REFRESH = 4;
  localparam int POS_AUTO_GAIN = 5;
  localparam int POS_GAIN_LOW = 4;
  localparam int POS_ADDR_INSERT_N = 7;
  localparam int POS_ADDR_OUTPUT_N = 6;
  localparam int POS_DEST_SOURCE = 5;

  // Multi-bit field positions
  localparam int CHANNEL_MSB = 6;
  localparam int POWER_MSB = 4;
  localparam int POWER_LSB = 3;
  localparam int CRYSTAL_MSB = 2;
  localparam int LEVEL_MSB = 3;
  localparam int PAYLOAD_MSB = 4;
  localparam int PREAMBLE_MSB = 5;
  localparam int PREAMBLE_LSB = 4;

  // Serial engine states
  typedef enum logic [2:0] {
    TCR_IDLE,
    TCR_ADDR,
    TCR_WDATA,
    TCR_RDATA,
    TCR_DONE
  } tcr_state_e;

endpackage

// ### core/tcr_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module tcr_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  // First stage feeds only the second stage
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end

endmodule

`default_nettype wire

// ### core/tcr_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

module tcr_config_regs
  import tcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial configuration pins
  input wire logic cs,
  input wire logic sclk,
  input wire logic sdat_in,
  output logic sdat_out,
  output logic sdat_oe,
  // Measured signal level from the converter
  input wire logic [3:0] level_adc,
  // Signal detect pin
  output logic signal_detect_pin,
  // Configuration to the radio
  output logic tx_mode,
  output logic [6:0] rf_channel_index,
  output logic [1:0] tx_power_level,
  output logic [2:0] crystal_freq_sel,
  output logic burst_mode,
  output logic bit_rate_select,
  output logic scramble_en,
  output logic crc_en,
  output logic crc_fail_keep,
  output logic auto_gain_enable,
  output logic level_gain_low,
  output logic sender_addr_insert,
  output logic sender_addr_output,
  output logic dest_addr_source,
  output logic [5:0] payload_len,
  output logic [4:0] preamble_bits
);

  logic [2:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic sdat_s;
  logic [3:0] level_s;
  logic sclk_d_reg;
  logic sclk_d_next;
  logic sclk_rise;
  tcr_state_e state_reg;
  tcr_state_e state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [6:0] addr_reg;
  logic [6:0] addr_next;
  logic [7:0] in_byte;
  logic [6:0] in_addr;
  logic we;
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] regs_next [NUM_REGS];
  logic refresh_eff;
  logic detect_reg;
  logic detect_next;
  logic [3:0] signal_level_threshold;
  logic [3:0] signal_level_value;
  logic [55:0] cfg_flat;
  logic [3:0] level_prev_reg;
  logic [3:0] level_prev_next;
  logic level_stable;
  logic [7:0] addr_word;

  // Pins and converter output come from other domains
  tcr_sync2 #(.WIDTH(3)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({cs, sclk, sdat_in}),
    .q(pins_s)
  );

  tcr_sync2 #(.WIDTH(4)) u_level_sync (
    .clk(clk),
    .rst(rst),
    .d(level_adc),
    .q(level_s)
  );

  // Data and clock share the same lag, so sampling stays aligned
  assign cs_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdat_s = pins_s[0];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign in_byte = {shift_reg[6:0], sdat_s};
  assign in_addr = {shift_reg[5:0], sdat_s};

  // Read data; unbuilt addresses read as zero
  function automatic logic [7:0] read_word(input logic [6:0] a);
    logic [7:0] w;
    w = 8'h00;
    if (a < 7'(NUM_REGS)) begin
      w = regs_reg[a[2:0]];
    end
    return w;
  endfunction

  // Serial engine next state
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    we = 1'b0;
    sclk_d_next = sclk_s;
    if (!cs_s) begin
      state_next = TCR_IDLE;
      cnt_next = 3'h0;
    end else begin
      case (state_reg)
        TCR_IDLE: begin
          state_next = TCR_ADDR;
          cnt_next = 3'h0;
        end
        TCR_ADDR: begin
          if (sclk_rise) begin
            shift_next = in_byte;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              addr_next = in_addr;
              if (shift_reg[6]) begin
                state_next = TCR_WDATA;
              end else begin
                state_next = TCR_RDATA;
                shift_next = read_word(in_addr);
              end
            end
          end
        end
        TCR_WDATA: begin
          if (sclk_rise) begin
            shift_next = in_byte;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              we = 1'b1;
              state_next = TCR_DONE;
            end
          end
        end
        TCR_RDATA: begin
          // Shift just after the host sampled; lag beats the hold time
          if (sclk_rise) begin
            shift_next = {shift_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              state_next = TCR_DONE;
            end
          end
        end
        TCR_DONE: begin
          // No auto increment; only a drop of select restarts
          state_next = TCR_DONE;
        end
        default: begin
          state_next = TCR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= TCR_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 3'h0;
      addr_reg <= 7'h00;
      sclk_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      sclk_d_reg <= sclk_d_next;
    end
  end

  // Pin drive during the read data byte
  assign sdat_out = shift_reg[7];
  assign sdat_oe = (state_reg == TCR_RDATA);

  // Level refresh always runs in burst mode
  assign refresh_eff = regs_reg[2][POS_BURST_MODE] | regs_reg[3][POS_LEVEL_REFRESH];

  // Register file next values; hardware level update wins over a write
  always_comb begin
    regs_next = regs_reg;
    addr_word = read_word(addr_reg); // Word at the latched address, for checks
    if (we && addr_reg <= ADDR_MAP_LAST && addr_reg < 7'(NUM_REGS)) begin
      regs_next[addr_reg[2:0]] = shift_next;
    end
    if (refresh_eff && level_stable) begin
      regs_next[4][LEVEL_MSB:0] = level_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regs_reg[0] <= RST_DIRECTION_CHANNEL;
      regs_reg[1] <= RST_TX_POWER_CRYSTAL;
      regs_reg[2] <= RST_DATA_FUNCTION_CTRL;
      regs_reg[3] <= RST_SIGNAL_LEVEL_CTRL;
      regs_reg[4] <= RST_SIGNAL_LEVEL_VALUE_GAIN;
      regs_reg[5] <= RST_PACKET_FORMAT_CTRL;
      regs_reg[6] <= RST_PREAMBLE_CTRL;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // Signal detect compare, registered for a clean pin
  assign signal_level_threshold = regs_reg[3][LEVEL_MSB:0];
  assign signal_level_value = regs_reg[4][LEVEL_MSB:0];
  // Level word crosses bit by bit; a skewed sample never matches twice
  assign level_stable = (level_s == level_prev_reg);

  always_comb begin
    detect_next = (signal_level_value > signal_level_threshold);
    level_prev_next = level_s;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      detect_reg <= 1'b0;
      level_prev_reg <= 4'h0;
    end else begin
      detect_reg <= detect_next;
      level_prev_reg <= level_prev_next;
    end
  end

  assign signal_detect_pin = detect_reg;

  // Configuration decode; mode-specific fields gated by data mode
  assign tx_mode = regs_reg[0][POS_TX_MODE];
  assign rf_channel_index = regs_reg[0][CHANNEL_MSB:0];
  assign tx_power_level = regs_reg[1][POWER_MSB:POWER_LSB];
  assign crystal_freq_sel = regs_reg[1][CRYSTAL_MSB:0];
  assign burst_mode = regs_reg[2][POS_BURST_MODE];
  assign bit_rate_select = regs_reg[2][POS_BIT_RATE];
  assign scramble_en = burst_mode & regs_reg[2][POS_SCRAMBLE_EN];
  assign crc_en = burst_mode & regs_reg[2][POS_CRC_EN];
  assign crc_fail_keep = burst_mode & ~tx_mode & regs_reg[2][POS_CRC_FAIL_KEEP];
  // Burst mode keeps gain control on, the safe default
  assign auto_gain_enable = burst_mode | regs_reg[4][POS_AUTO_GAIN];
  assign level_gain_low = ~burst_mode & regs_reg[4][POS_GAIN_LOW];
  assign sender_addr_insert = burst_mode & ~regs_reg[5][POS_ADDR_INSERT_N];
  assign sender_addr_output = burst_mode & ~regs_reg[5][POS_ADDR_OUTPUT_N];
  assign dest_addr_source = burst_mode & regs_reg[5][POS_DEST_SOURCE];
  assign payload_len = burst_mode ? {1'b0, regs_reg[5][PAYLOAD_MSB:0]} + 6'h01 : 6'h00;
  assign preamble_bits = burst_mode ?
    5'(({3'b000, regs_reg[6][PREAMBLE_MSB:PREAMBLE_LSB]} + 5'h01) << 2) : 5'h00;

  // Snapshot of stored settings, measured level masked out
  assign cfg_flat = {regs_reg[0], regs_reg[1], regs_reg[2], regs_reg[3],
                     regs_reg[4][7:4], 4'h0, regs_reg[5], regs_reg[6]};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Address byte finished with direction bit clear
  sequence s_read_addr;
    state_reg == TCR_ADDR && sclk_rise && cnt_reg == 3'h7 && !shift_reg[6] && cs_s;
  endsequence

  // Data byte finished in a write to the direction and channel register
  sequence s_write_reg0;
    we && addr_reg == ADDR_DIRECTION_CHANNEL;
  endsequence

  a_unmapped_write: assert property (
    (we && addr_reg >= 7'(NUM_REGS)) |=> cfg_flat == $past(cfg_flat))
    else $error("write outside built registers changed a setting");
  a_mode_write: assert property (
    s_write_reg0 |=> tx_mode == $past(in_byte[7]))
    else $error("direction bit not taken from written byte");
  a_channel_write: assert property (
    s_write_reg0 |=> rf_channel_index == $past(in_byte[6:0]))
    else $error("channel index not taken from written byte");
  a_crystal_write: assert property (
    (we && addr_reg == ADDR_TX_POWER_CRYSTAL) |=> crystal_freq_sel == $past(in_byte[2:0]))
    else $error("crystal select not taken from written byte");
  a_burst_gate: assert property (
    !burst_mode |-> !scramble_en && !crc_en && !crc_fail_keep && payload_len == 6'h00)
    else $error("burst feature active in continuous mode");
  a_level_hold: assert property (
    (!burst_mode && !regs_reg[3][POS_LEVEL_REFRESH]) |=>
      signal_level_value == $past(signal_level_value) || $past(we))
    else $error("level value moved while refresh was off");
  a_level_follow: assert property (
    burst_mode && level_stable |=> signal_level_value == $past(level_s))
    else $error("level value did not track the converter");
  a_detect_level: assert property (
    1'b1 |=> signal_detect_pin == ($past(signal_level_value) > $past(signal_level_threshold)))
    else $error("signal detect pin does not match level compare");
  a_payload_range: assert property (
    burst_mode |-> payload_len >= 6'h01 && payload_len <= 6'h20)
    else $error("payload length outside 1 to 32");
  a_preamble_len: assert property (
    burst_mode && regs_reg[6][PREAMBLE_MSB:PREAMBLE_LSB] == 2'b11 |-> preamble_bits == 5'h10)
    else $error("longest preamble code is not 16 bits");
  a_read_drive: assert property (
    s_read_addr |=> sdat_oe && sdat_out == addr_word[7])
    else $error("read byte not driven after address byte");
  a_select_abort: assert property (
    !cs_s |=> state_reg == TCR_IDLE && !sdat_oe)
    else $error("engine not reset by dropped select");

endmodule

`default_nettype wire

// ### tb/tcr_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module tcr_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic cs,
  output logic sclk,
  output logic sdat_line,
  input wire logic sdat_out,
  input wire logic sdat_oe
);
  logic drv_bit = 1'b0;
  logic drv_en = 1'b0;
  logic last_q = 1'b0;

  // Select and clock idle low; the clock stands still between frames
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
  end

  // Undriven line toggles so a stale bit never reads as good data
  always @(posedge clk) begin
    last_q <= sdat_line;
  end
  assign sdat_line = sdat_oe ? sdat_out : (drv_en ? drv_bit : ~last_q);

  // One access: command byte, then data byte, both MSB first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nbits,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(posedge clk);
    cs <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      drv_en <= (i < 8) || cmd[7];
      drv_bit <= sh[15 - i];
      repeat (4) @(posedge clk);
      if (i >= 8) begin
        rd = {rd[6:0], sdat_line};
      end
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    cs <= 1'b0;
    drv_en <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ### tb/transceiver_config_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

module transceiver_config_regs_tb;
  import tcr_pkg::*;
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } tcr_row_s;

  // Bench signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] level_adc = 4'h0;
  logic cs, sclk, sdat_line, sdat_out, sdat_oe, signal_detect_pin, tx_mode, burst_mode;
  logic bit_rate_select, scramble_en, crc_en, crc_fail_keep, auto_gain_enable;
  logic level_gain_low, sender_addr_insert, sender_addr_output, dest_addr_source;
  logic [6:0] rf_channel_index;
  logic [1:0] tx_power_level;
  logic [2:0] crystal_freq_sel;
  logic [5:0] payload_len;
  logic [4:0] preamble_bits;
  logic [7:0] rd;
  int n_errors = 0;
  int checked = 0;
  logic [7:0] rstv [7] = '{RST_DIRECTION_CHANNEL, RST_TX_POWER_CRYSTAL,
    RST_DATA_FUNCTION_CTRL, RST_SIGNAL_LEVEL_CTRL, RST_SIGNAL_LEVEL_VALUE_GAIN,
    RST_PACKET_FORMAT_CTRL, RST_PREAMBLE_CTRL};
  // Write then read back; unmapped places read zero
  tcr_row_s rows [8] = '{'{7'h00, 8'h81, 8'h81}, '{7'h01, 8'h1c, 8'h1c},
    '{7'h02, 8'h79, 8'h79}, '{7'h03, 8'h1f, 8'h1f}, '{7'h05, 8'h1f, 8'h1f},
    '{7'h06, 8'h80, 8'h80}, '{7'h07, 8'h55, 8'h00}, '{7'h18, 8'haa, 8'h00}};

  // 25 MHz clock
  always #20 clk = ~clk;

  tcr_config_regs uut (.clk(clk), .rst(rst), .cs(cs), .sclk(sclk), .sdat_in(sdat_line),
    .sdat_out(sdat_out), .sdat_oe(sdat_oe), .level_adc(level_adc),
    .signal_detect_pin(signal_detect_pin), .tx_mode(tx_mode),
    .rf_channel_index(rf_channel_index), .tx_power_level(tx_power_level),
    .crystal_freq_sel(crystal_freq_sel), .burst_mode(burst_mode),
    .bit_rate_select(bit_rate_select), .scramble_en(scramble_en), .crc_en(crc_en),
    .crc_fail_keep(crc_fail_keep), .auto_gain_enable(auto_gain_enable),
    .level_gain_low(level_gain_low), .sender_addr_insert(sender_addr_insert),
    .sender_addr_output(sender_addr_output), .dest_addr_source(dest_addr_source),
    .payload_len(payload_len), .preamble_bits(preamble_bits));

  tcr_host_model host (.clk(clk), .cs(cs), .sclk(sclk), .sdat_line(sdat_line),
    .sdat_out(sdat_out), .sdat_oe(sdat_oe));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a}, d, 16, rd);
  endtask

  task automatic rdr(input logic [6:0] a, input logic [7:0] e);
    host.xfer({1'b0, a}, 8'h00, 16, rd);
    chk(rd, e);
  endtask

  task automatic complete_run;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog, well beyond the expected run of about 6700 cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({7'h0, sdat_oe}, 8'h00);
    chk({2'h0, payload_len}, 8'h10);
    chk({3'h0, preamble_bits}, 8'h10);
    for (int i = 0; i < NUM_REGS; i++) begin
      rdr(7'(i), rstv[i]);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a, rows[i].e);
    end
    chk({7'h0, tx_mode}, 8'h01);
    chk({1'b0, rf_channel_index}, 8'h01);
    chk({3'h0, tx_power_level, crystal_freq_sel}, 8'h1c);
    chk({6'h0, burst_mode, bit_rate_select}, 8'h03);
    chk({6'h0, scramble_en, crc_en}, 8'h03);
    chk({7'h0, crc_fail_keep}, 8'h00);
    chk({2'h0, payload_len}, 8'h20);
    chk({3'h0, preamble_bits}, 8'h04);
    $display("test table done");
    // Crystal codes 0 to 4 and every preamble code
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_TX_POWER_CRYSTAL, 8'(c));
      chk({5'h0, crystal_freq_sel}, 8'(c));
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_PREAMBLE_CTRL, 8'h80 | 8'(c << 4));
      chk({3'h0, preamble_bits}, 8'(4 * c + 4));
    end
    // Address options and shortest payload
    wr(ADDR_PACKET_FORMAT_CTRL, 8'he0);
    chk({5'h0, sender_addr_insert, sender_addr_output, dest_addr_source}, 8'h01);
    chk({2'h0, payload_len}, 8'h01);
    wr(ADDR_PACKET_FORMAT_CTRL, 8'h40);
    chk({5'h0, sender_addr_insert, sender_addr_output, dest_addr_source}, 8'h04);
    // Receive with top channel keeps bad packets
    wr(ADDR_DIRECTION_CHANNEL, 8'h7f);
    chk({tx_mode, rf_channel_index}, 8'h7f);
    chk({7'h0, crc_fail_keep}, 8'h01);
    // Write cut short by select dropping leaves the register alone
    host.xfer({1'b1, ADDR_DIRECTION_CHANNEL}, 8'h05, 12, rd);
    rdr(ADDR_DIRECTION_CHANNEL, 8'h7f);
    $display("test codes done");
    // Detect strictly above threshold; equal level stays low
    wr(ADDR_SIGNAL_LEVEL_CTRL, 8'h17);
    level_adc <= 4'h8;
    repeat (8) @(posedge clk);
    chk({7'h0, signal_detect_pin}, 8'h01);
    rdr(ADDR_SIGNAL_LEVEL_VALUE_GAIN, 8'h28);
    level_adc <= 4'h7;
    repeat (8) @(posedge clk);
    chk({7'h0, signal_detect_pin}, 8'h00);
    // Continuous mode: held level, burst fields idle
    wr(ADDR_DATA_FUNCTION_CTRL, 8'h20);
    wr(ADDR_SIGNAL_LEVEL_CTRL, 8'h07);
    level_adc <= 4'hc;
    repeat (8) @(posedge clk);
    rdr(ADDR_SIGNAL_LEVEL_VALUE_GAIN, 8'h27);
    chk({4'h0, scramble_en, crc_en, crc_fail_keep, sender_addr_insert}, 8'h00);
    chk({2'h0, payload_len | {1'b0, preamble_bits}}, 8'h00);
    chk({7'h0, burst_mode}, 8'h00);
    wr(ADDR_SIGNAL_LEVEL_VALUE_GAIN, 8'h10);
    chk({6'h0, auto_gain_enable, level_gain_low}, 8'h01);
    wr(ADDR_SIGNAL_LEVEL_VALUE_GAIN, 8'h20);
    chk({6'h0, auto_gain_enable, level_gain_low}, 8'h02);
    wr(ADDR_SIGNAL_LEVEL_CTRL, 8'h17);
    repeat (8) @(posedge clk);
    rdr(ADDR_SIGNAL_LEVEL_VALUE_GAIN, 8'h2c);
    chk({7'h0, signal_detect_pin}, 8'h01);
    $display("test level done");
    complete_run();
  end
endmodule

`default_nettype wire
